/* File: rtl/csc_cfg.svh */
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// Register byte offsets on the APB
`define CSC_OFS_CTRL0 8'h00
`define CSC_OFS_CHSEL 8'h04
`define CSC_OFS_TCFG 8'h08
`define CSC_OFS_T16 8'h0C
`define CSC_OFS_T8 8'h10

// Primary control register fields
`define CSC_C0_ENABLE 7
`define CSC_C0_RANGE_HI 3
`define CSC_C0_RANGE_LO 2
`define CSC_C0_DIR 1
`define CSC_C0_XSEL 0

// Timer configuration register fields
`define CSC_TC_T8CS 0
`define CSC_TC_T16RUN 1
`define CSC_TC_T16CS_HI 3
`define CSC_TC_T16CS_LO 2
`define CSC_TC_GATE_EN 4
`define CSC_TC_TOGGLE 5
`define CSC_TC_GSS_HI 7
`define CSC_TC_GSS_LO 6

// Reset values
`define CSC_RST_CTRL0 8'h00
`define CSC_RST_CHSEL 4'h0
`define CSC_RST_TCFG 8'h00

// Instruction clock is the system clock divided by this
`define CSC_INSTR_DIV 4
`define CSC_CHANNELS 16

`endif

/* File: rtl/csc_pkg.sv */
package csc_pkg;
   typedef enum logic [1:0] {
      CSC_RNG_OFF = 2'b00,
      CSC_RNG_LOW = 2'b01,
      CSC_RNG_MED = 2'b10,
      CSC_RNG_HIGH = 2'b11
   } csc_range_e;

   typedef enum logic [1:0] {
      CSC_T16_INSTR = 2'b00,
      CSC_T16_SYS = 2'b01,
      CSC_T16_PIN = 2'b10,
      CSC_T16_SENSE = 2'b11
   } csc_t16_clk_e;

   typedef enum logic [1:0] {
      CSC_GSS_PIN = 2'b00,
      CSC_GSS_RSV1 = 2'b01,
      CSC_GSS_RSV2 = 2'b10,
      CSC_GSS_WDOG = 2'b11
   } csc_gate_src_e;

   typedef logic [15:0] csc_count_t;
endpackage

/* File: rtl/csc_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for the three asynchronous inputs
module csc_sync (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [2:0] i_async,
   output logic [2:0] o_sync
);
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic [2:0] nxt_meta;
   logic [2:0] nxt_sync;

   // First stage feeds only the second stage
   always_comb begin
      nxt_meta = i_async;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         meta_ff <= 3'h0;
         sync_ff <= 3'h0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign o_sync = sync_ff;
endmodule

/* File: rtl/csc_gate_timer16.sv */
`timescale 1ns/100ps
// 16-bit counter with gate control, level or toggle mode
module csc_gate_timer16 (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_run,
   input wire logic i_gate_enable,
   input wire logic i_toggle_mode,
   input wire logic i_gate_level,
   input wire logic i_count_tick,
   input wire logic i_load,
   input wire csc_pkg::csc_count_t i_load_value,
   output csc_pkg::csc_count_t o_count,
   output logic o_gate_open
);
   import csc_pkg::*;

   csc_count_t count_ff;
   csc_count_t nxt_count;
   logic gate_prev_ff;
   logic nxt_gate_prev;
   logic toggle_ff;
   logic nxt_toggle;
   logic gate_open;

   // Toggle flop flips on each gate rising edge; cleared outside toggle mode or while the gate is disabled
   always_comb begin
      nxt_gate_prev = i_gate_level;
      nxt_toggle = toggle_ff;
      if (!i_toggle_mode || !i_gate_enable) begin
         nxt_toggle = 1'b0;
      end else if (i_gate_level && !gate_prev_ff) begin
         nxt_toggle = !toggle_ff;
      end
      gate_open = i_toggle_mode ? toggle_ff : i_gate_level;
      nxt_count = count_ff;
      // Software load wins over a count in the same cycle
      if (i_load) begin
         nxt_count = i_load_value;
      end else if (i_run && (!i_gate_enable || gate_open) && i_count_tick) begin
         nxt_count = count_ff + 16'h0001;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         count_ff <= 16'h0000;
         gate_prev_ff <= 1'b0;
         toggle_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         gate_prev_ff <= nxt_gate_prev;
         toggle_ff <= nxt_toggle;
      end
   end

   assign o_count = count_ff;
   assign o_gate_open = i_gate_enable ? gate_open : 1'b1;
endmodule

/* File: rtl/csc_top.sv */
`timescale 1ns/100ps
`include "csc_cfg.svh"
module csc_top #(
   parameter bit P_WIDE_VARIANT = 1'b1
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_osc_direction,
   input wire logic i_timer8_ext_clock_pin,
   input wire logic i_timer16_gate_pin,
   input wire logic i_sleep,
   input wire logic i_watchdog_overflow,
   input wire logic i_wake_early,
   output logic o_sense_unit_power,
   output logic o_osc_run,
   output csc_pkg::csc_range_e o_osc_current_range,
   output logic [15:0] o_sense_input_select,
   output logic o_watchdog_restart
);
   import csc_pkg::*;

   // Software state
   logic sense_unit_enable_ff;
   logic nxt_sense_unit_enable;
   csc_range_e osc_current_range_ff;
   csc_range_e nxt_osc_current_range;
   logic timer8_ext_source_sel_ff;
   logic nxt_timer8_ext_source_sel;
   logic [3:0] sense_channel_code_ff;
   logic [3:0] nxt_sense_channel_code;
   logic [7:0] tcfg_ff;
   logic [7:0] nxt_tcfg;
   logic [7:0] timer8_ff;
   logic [7:0] nxt_timer8;

   // Bus state
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;

   // Link-facing state
   logic [1:0] instr_div_ff;
   logic [1:0] nxt_instr_div;
   logic dir_prev_ff;
   logic nxt_dir_prev;
   logic ext_prev_ff;
   logic nxt_ext_prev;
   logic power_ff;
   logic nxt_power;
   logic osc_run_ff;
   logic nxt_osc_run;
   csc_range_e range_out_ff;
   csc_range_e nxt_range_out;
   logic [15:0] select_ff;
   logic [15:0] nxt_select;
   logic wd_restart_ff;
   logic nxt_wd_restart;

   // Combinational helpers
   logic [2:0] sync_in;
   logic dir_sync;
   logic ext_sync;
   logic gate_pin_sync;
   logic [3:0] chan_mask;
   logic wr_en;
   logic setup;
   logic hit;
   logic instr_tick;
   logic sense_edge;
   logic ext_edge;
   logic t8_tick;
   logic t16_tick;
   logic t16_gate;
   csc_count_t t16_count;
   logic t16_gate_open;
   csc_t16_clk_e t16_clk_sel;
   csc_gate_src_e gate_src;

   // Direction, timer8 pin and gate pin are asynchronous to the system clock
   csc_sync u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_async({i_timer16_gate_pin, i_timer8_ext_clock_pin, i_osc_direction}),
      .o_sync(sync_in)
   );

   assign dir_sync = sync_in[0];
   assign ext_sync = sync_in[1];
   assign gate_pin_sync = sync_in[2];

   // Small variant drops the top channel bit so it stores and reads zero
   assign chan_mask = P_WIDE_VARIANT ? 4'hF : 4'h7;
   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && pready_ff && i_pwrite;
   assign hit = (i_paddr == `CSC_OFS_CTRL0) || (i_paddr == `CSC_OFS_CHSEL) ||
                (i_paddr == `CSC_OFS_TCFG) || (i_paddr == `CSC_OFS_T16) ||
                (i_paddr == `CSC_OFS_T8);
   assign t16_clk_sel = csc_t16_clk_e'(tcfg_ff[`CSC_TC_T16CS_HI:`CSC_TC_T16CS_LO]);
   assign gate_src = csc_gate_src_e'(tcfg_ff[`CSC_TC_GSS_HI:`CSC_TC_GSS_LO]);

   // Instruction clock enable: system clock divided by four, stopped in Sleep
   always_comb begin
      nxt_instr_div = instr_div_ff + 2'd1;
      instr_tick = (instr_div_ff == 2'(`CSC_INSTR_DIV - 1)) && !i_sleep;
      nxt_dir_prev = dir_sync;
      nxt_ext_prev = ext_sync;
      // Oscillator edges reach Timer16 regardless of Sleep while it runs
      sense_edge = osc_run_ff && dir_sync && !dir_prev_ff;
      ext_edge = ext_sync && !ext_prev_ff;
   end

   // Timer8 clock choice; nothing reaches it while asleep
   always_comb begin
      if (i_sleep) begin
         t8_tick = 1'b0;
      end else if (!tcfg_ff[`CSC_TC_T8CS]) begin
         t8_tick = instr_tick;
      end else begin
         t8_tick = timer8_ext_source_sel_ff ? sense_edge : ext_edge;
      end
   end

   // Timer16 clock and gate choice
   always_comb begin
      unique case (t16_clk_sel)
         CSC_T16_INSTR: t16_tick = instr_tick;
         CSC_T16_SYS: t16_tick = 1'b1;
         CSC_T16_PIN: t16_tick = ext_edge;
         CSC_T16_SENSE: t16_tick = sense_edge;
      endcase
      // Reserved gate codes hold the gate level low
      unique case (gate_src)
         CSC_GSS_WDOG: t16_gate = i_watchdog_overflow;
         CSC_GSS_PIN: t16_gate = gate_pin_sync;
         CSC_GSS_RSV1: t16_gate = 1'b0;
         CSC_GSS_RSV2: t16_gate = 1'b0;
      endcase
   end

   csc_gate_timer16 u_timer16 (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_run(tcfg_ff[`CSC_TC_T16RUN]),
      .i_gate_enable(tcfg_ff[`CSC_TC_GATE_EN]),
      .i_toggle_mode(tcfg_ff[`CSC_TC_TOGGLE]),
      .i_gate_level(t16_gate),
      .i_count_tick(t16_tick),
      .i_load(wr_en && (i_paddr == `CSC_OFS_T16)),
      .i_load_value(i_pwdata[15:0]),
      .o_count(t16_count),
      .o_gate_open(t16_gate_open)
   );

   // Register writes take effect at the access edge; timer8 load beats its tick
   always_comb begin
      nxt_sense_unit_enable = sense_unit_enable_ff;
      nxt_osc_current_range = osc_current_range_ff;
      nxt_timer8_ext_source_sel = timer8_ext_source_sel_ff;
      nxt_sense_channel_code = sense_channel_code_ff;
      nxt_tcfg = tcfg_ff;
      nxt_timer8 = t8_tick ? timer8_ff + 8'h01 : timer8_ff;
      if (wr_en) begin
         unique case (i_paddr)
            `CSC_OFS_CTRL0: begin
               nxt_sense_unit_enable = i_pwdata[`CSC_C0_ENABLE];
               nxt_osc_current_range = csc_range_e'(i_pwdata[`CSC_C0_RANGE_HI:`CSC_C0_RANGE_LO]);
               nxt_timer8_ext_source_sel = i_pwdata[`CSC_C0_XSEL];
            end
            `CSC_OFS_CHSEL: nxt_sense_channel_code = i_pwdata[3:0] & chan_mask;
            `CSC_OFS_TCFG: nxt_tcfg = i_pwdata[7:0];
            `CSC_OFS_T8: nxt_timer8 = i_pwdata[7:0];
            default: nxt_tcfg = tcfg_ff;
         endcase
      end
   end

   // Read data is captured in the setup cycle; pready rises for the access cycle
   always_comb begin
      nxt_pready = setup;
      nxt_pslverr = setup && !hit;
      nxt_prdata = 32'h0000_0000;
      if (setup) begin
         unique case (i_paddr)
            // Bits 6-4 read zero; direction is read-only
            `CSC_OFS_CTRL0: nxt_prdata = {24'h00_0000, sense_unit_enable_ff, 3'b000,
                                          osc_current_range_ff, dir_sync, timer8_ext_source_sel_ff};
            `CSC_OFS_CHSEL: nxt_prdata = {28'h000_0000, sense_channel_code_ff};
            `CSC_OFS_TCFG: nxt_prdata = {24'h00_0000, tcfg_ff};
            `CSC_OFS_T16: nxt_prdata = {15'h0000, t16_gate_open, t16_count};
            `CSC_OFS_T8: nxt_prdata = {24'h00_0000, timer8_ff};
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Pin-side outputs: power, oscillator, channel mux, watchdog restart
   always_comb begin
      nxt_power = sense_unit_enable_ff;
      nxt_osc_run = sense_unit_enable_ff && (osc_current_range_ff != CSC_RNG_OFF);
      nxt_range_out = sense_unit_enable_ff ? osc_current_range_ff : CSC_RNG_OFF;
      // Another wake source in Sleep restarts the watchdog, pushing back its overflow
      nxt_wd_restart = i_wake_early && i_sleep;
   end

   // One select line per sensing input
   genvar g;
   generate
      for (g = 0; g < `CSC_CHANNELS; g++) begin : g_chan
         // Codes past the implemented inputs select nothing
         assign nxt_select[g] = sense_unit_enable_ff && (sense_channel_code_ff == 4'(g)) &&
                                (P_WIDE_VARIANT || (g < 8));
      end
   endgenerate

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         sense_unit_enable_ff <= 1'b0;
         osc_current_range_ff <= CSC_RNG_OFF;
         timer8_ext_source_sel_ff <= 1'b0;
         sense_channel_code_ff <= `CSC_RST_CHSEL;
         tcfg_ff <= `CSC_RST_TCFG;
         timer8_ff <= 8'h00;
      end else begin
         sense_unit_enable_ff <= nxt_sense_unit_enable;
         osc_current_range_ff <= nxt_osc_current_range;
         timer8_ext_source_sel_ff <= nxt_timer8_ext_source_sel;
         sense_channel_code_ff <= nxt_sense_channel_code;
         tcfg_ff <= nxt_tcfg;
         timer8_ff <= nxt_timer8;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         instr_div_ff <= 2'd0;
         dir_prev_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
         power_ff <= 1'b0;
         osc_run_ff <= 1'b0;
         range_out_ff <= CSC_RNG_OFF;
         select_ff <= 16'h0000;
         wd_restart_ff <= 1'b0;
      end else begin
         instr_div_ff <= nxt_instr_div;
         dir_prev_ff <= nxt_dir_prev;
         ext_prev_ff <= nxt_ext_prev;
         power_ff <= nxt_power;
         osc_run_ff <= nxt_osc_run;
         range_out_ff <= nxt_range_out;
         select_ff <= nxt_select;
         wd_restart_ff <= nxt_wd_restart;
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_sense_unit_power = power_ff;
   assign o_osc_run = osc_run_ff;
   assign o_osc_current_range = range_out_ff;
   assign o_sense_input_select = select_ff;
   assign o_watchdog_restart = wd_restart_ff;
endmodule

/* File: bench/csc_pad_model.sv */
`timescale 1ns/100ps
// Sense pad with its oscillator, seen as the direction level of the triangle wave
module csc_pad_model (
   input wire logic i_sys_clk,
   input wire logic i_osc_run,
   output logic o_dir
);
   int cnt_ff = 0;
   initial o_dir = 1'b0;
   // Pin kept analog and input, so the wave runs while the oscillator runs
   // Flips every 8 clocks; a stopped oscillator keeps its last level
   always @(posedge i_sys_clk) begin
      if (i_osc_run) begin
         cnt_ff <= (cnt_ff == 7) ? 0 : cnt_ff + 1;
         if (cnt_ff == 7) begin
            o_dir <= ~o_dir;
         end
      end
   end
endmodule

/* File: bench/csc_chk.sv */
`timescale 1ns/100ps
`include "csc_cfg.svh"
// Port-level checks of the sensing control block
module csc_chk (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_sleep,
   input wire logic i_wake_early,
   input wire logic o_sense_unit_power,
   input wire logic o_osc_run,
   input wire csc_pkg::csc_range_e o_osc_current_range,
   input wire logic [15:0] o_sense_input_select,
   input wire logic o_watchdog_restart
);
   import csc_pkg::*;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   // Completed write; outputs follow two edges later
   logic wr_done;
   assign wr_done = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
   a_pready_answer: assert property (i_psel && !i_penable |=> o_pready)
      else $error("No ready after setup");
   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("Ready held too long");
   a_slverr_pair: assert property (o_pslverr |-> o_pready)
      else $error("Error flag without ready");
   a_enable_follow: assert property (wr_done && i_paddr == `CSC_OFS_CTRL0 |-> ##2
      o_sense_unit_power == $past(i_pwdata[7], 2)) else $error("Power does not follow enable");
   a_off_quiet: assert property (!o_sense_unit_power |->
      o_sense_input_select == 16'h0000 && !o_osc_run) else $error("Disabled unit still active");
   a_range_run: assert property (o_osc_run == (o_sense_unit_power && o_osc_current_range != CSC_RNG_OFF))
      else $error("Oscillator run disagrees with range");
   a_chan_select: assert property (wr_done && i_paddr == `CSC_OFS_CHSEL && o_sense_unit_power |-> ##2
      o_sense_input_select == 16'h0001 << $past(i_pwdata[3:0], 2)) else $error("Wrong input selected");
   a_restart_pulse: assert property (i_wake_early && i_sleep |=> o_watchdog_restart)
      else $error("No watchdog restart on early wake");
   a_restart_cause: assert property (o_watchdog_restart |-> $past(i_wake_early) && $past(i_sleep))
      else $error("Watchdog restart without cause");
endmodule

/* File: bench/capacitive_sense_oscillator_control_tb.sv */
`timescale 1ns/100ps
module capacitive_sense_oscillator_control_tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [15:0] sel; logic [1:0] rng;} csc_row_s;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, osc_dir, t8pin, sleep, wdog, wake;
   logic power, osc_run, restart;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, c1;
   logic e;
   logic [1:0] rng;
   logic [15:0] sel;
   int err_count = 0;
   int checked = 0;
   csc_row_s rows[9] = '{'{8'h00, 32'h0000_0004, 32'h0000_0004, 16'h0000, 2'h0},
      '{8'h04, 32'h0000_0003, 32'h0000_0003, 16'h0000, 2'h0},
      '{8'h00, 32'hFFFF_FFFF, 32'h0000_008D, 16'h0008, 2'h3},
      '{8'h04, 32'hFFFF_FFFF, 32'h0000_000F, 16'h8000, 2'h3},
      '{8'h00, 32'h0000_0088, 32'h0000_0088, 16'h8000, 2'h2},
      '{8'h00, 32'h0000_0084, 32'h0000_0084, 16'h8000, 2'h1},
      '{8'h04, 32'h0000_0000, 32'h0000_0000, 16'h0001, 2'h1},
      '{8'h00, 32'h0000_0080, 32'h0000_0080, 16'h0001, 2'h0},
      '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 16'h0001, 2'h0}};
   csc_top u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_osc_direction(osc_dir), .i_timer8_ext_clock_pin(t8pin), .i_timer16_gate_pin(1'b0),
      .i_sleep(sleep), .i_watchdog_overflow(wdog), .i_wake_early(wake), .o_sense_unit_power(power),
      .o_osc_run(osc_run), .o_osc_current_range(rng), .o_sense_input_select(sel), .o_watchdog_restart(restart));
   csc_pad_model u_pad (.i_sys_clk(clk), .i_osc_run(osc_run), .o_dir(osc_dir));
   // Free-running system clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task complete_run();
      $display("Checks %0d, errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One APB transfer; data taken while ready stands, released after its edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(negedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(negedge clk);
      end
      if (n == 20) begin
         err_count++;
         complete_run();
      end
      q = prdata;
      e = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Main sequence: reset, table of register cases, then timer and status cases
   initial begin
      {rstn, psel, penable, pwrite, t8pin, sleep, wdog, wake} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cyc(16);
      rstn <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, 8'(4 * k), 32'h0000_0000);
         chk("reset value", q, 32'h0000_0000);
      end
      chk("select at reset", 32'(sel), 32'h0000_0000);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0000_0000);
         chk("read data", q & ((rows[i].a == 8'h00) ? 32'hFFFF_FFFD : 32'hFFFF_FFFF), rows[i].rd);
         chk("slave error", 32'(e), 32'(rows[i].a == 8'h40));
         chk("input select", 32'(sel), 32'(rows[i].sel));
         chk("current range", 32'(rng), 32'(rows[i].rng));
      end
      // Sleep measurement: gate, toggle, gate enable, run, then unit, clear, sleep
      apb(1'b1, 8'h08, 32'h0000_00FE);
      apb(1'b1, 8'h00, 32'h0000_008C);
      apb(1'b1, 8'h0C, 32'h0000_0000);
      sleep <= 1'b1;
      cyc(100);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("count before gate", q, 32'h0000_0000);
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      cyc(20);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("gate open", 32'(q[16]), 32'h0000_0001);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      cyc(180);
      // Time base comes from the watchdog, never from the timer being clocked
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      cyc(5);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      c1 = q; // unloaded count, the base of the software threshold
      chk("counted in sleep", 32'(c1[15:0] != 16'h0000 && c1[16] == 1'b0), 32'h0000_0001);
      cyc(50);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("count held", q, c1);
      // Timer8 on the sense oscillator: frozen asleep, counts awake
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b1, 8'h00, 32'h0000_008D);
      apb(1'b1, 8'h10, 32'h0000_0000);
      cyc(100);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("timer8 in sleep", q, 32'h0000_0000);
      sleep <= 1'b0;
      cyc(100);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("timer8 on oscillator", 32'(q != 32'h0000_0000), 32'h0000_0001);
      // Pin source: the running oscillator is ignored, five pin edges counted
      apb(1'b1, 8'h00, 32'h0000_008C);
      apb(1'b1, 8'h10, 32'h0000_0000);
      cyc(50);
      repeat (5) begin
         t8pin <= 1'b1;
         cyc(4);
         t8pin <= 1'b0;
         cyc(4);
      end
      cyc(8);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("timer8 pin edges", q, 32'h0000_0005);
      apb(1'b1, 8'h08, 32'h0000_0000);
      apb(1'b1, 8'h10, 32'h0000_0000);
      cyc(40);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("timer8 instruction clock", 32'(q != 32'h0000_0000), 32'h0000_0001);
      // Stopped oscillator holds a level that the status bit must show
      apb(1'b1, 8'h00, 32'h0000_0080);
      cyc(10);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("direction status", 32'(q[1]), 32'(osc_dir));
      // Second reset in mid-run clears the control bits
      rstn <= 1'b0;
      cyc(4);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'h00, 32'h0000_0000);
      // Stopped oscillator may hold either level, so the read-only status bit is masked
      chk("control after reset", q & 32'hFFFF_FFFD, 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("channel after reset", q, 32'h0000_0000);
      complete_run();
   end
endmodule
bind csc_top csc_chk u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_sleep(i_sleep), .i_wake_early(i_wake_early), .o_sense_unit_power(o_sense_unit_power),
   .o_osc_run(o_osc_run), .o_osc_current_range(o_osc_current_range),
   .o_sense_input_select(o_sense_input_select), .o_watchdog_restart(o_watchdog_restart));
